// *** core/icr_map.vh ***
// Address map, field positions, defaults and codes of the imager register bank
`ifndef ICR_MAP_VH
`define ICR_MAP_VH
// ------------------------------------------------------------
// Serial word layout
// ------------------------------------------------------------
`define ICR_ADDR_BITS 12
`define ICR_DATA_BITS 28
`define ICR_WORD_BITS 40
// ------------------------------------------------------------
// Fixed area
// ------------------------------------------------------------
`define ICR_FIX_LAST 8'h91
`define ICR_A_CTRL 8'h00
`define ICR_A_OUTFMT 8'h01
`define ICR_A_CDSGAIN 8'h04
`define ICR_A_GAIN 8'h05
`define ICR_A_CLAMPLVL 8'h06
`define ICR_A_SWRESET 8'h10
`define ICR_A_UPDLINE 8'h18
`define ICR_A_PATCNT 8'h90
`define ICR_A_SEQCNT 8'h91
`define ICR_A_SG_FIRST 8'h70
`define ICR_A_SG_LAST 8'h73
// ------------------------------------------------------------
// Defaults
// ------------------------------------------------------------
`define ICR_DEF_CTRL 28'h0000007
`define ICR_DEF_OUTFMT 28'h0000008
`define ICR_DEF_CDSGAIN 28'h0000001
`define ICR_DEF_GAIN 28'h000000f
`define ICR_DEF_CLAMPLVL 28'h00001ec
// ------------------------------------------------------------
// Configurable area
// ------------------------------------------------------------
`define ICR_CFG_BASE 12'h400
`define ICR_PAT_WORDS 12'h028
`define ICR_SEQ_WORDS 12'h014
`define ICR_FLD_WORDS 12'h00c
// ------------------------------------------------------------
// Update classes and control fields
// ------------------------------------------------------------
`define ICR_UPD_SCK 2'h0
`define ICR_UPD_VD 2'h1
`define ICR_UPD_SG 2'h2
`define ICR_B_STANDBY 1:0
`define ICR_B_CLAMP_ON 2
`define ICR_B_SETTLE_FAST 3
`define ICR_B_GAIN_FAST 4
`define ICR_B_BLANK_LVL 5
`define ICR_B_DC_BYPASS 6
`define ICR_B_SUBSEL 15:11
`define ICR_B_SWRESET 0
`define ICR_SUB_HIGH 5'h1e
`define ICR_SUB_LOW 5'h1f
`endif

// *** core/icr_mem.v ***
// Simple dual-port word memory with registered read data
`timescale 1ns/1ps
module icr_mem #(
	parameter AW = 10,
	parameter DW = 28
) (
	input wire clk,
	input wire ce,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// *** core/icr_serial.v ***
// Three-wire serial write receiver with address auto-increment
`timescale 1ns/1ps
`include "icr_map.vh"
module icr_serial (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire serial_load_n,
	input wire serial_clk,
	input wire serial_data,
	output reg word_valid,
	output reg [`ICR_ADDR_BITS-1:0] word_addr,
	output reg [`ICR_DATA_BITS-1:0] word_data
);
	reg sck_q_reg;
	reg addr_phase_reg;
	reg [5:0] bit_cnt_reg;
	reg [`ICR_DATA_BITS-1:0] shift_reg;
	wire sck_rise = serial_clk & ~sck_q_reg;

	always @(posedge mclk) begin
		if (rst) begin
			sck_q_reg <= 1'b0;
			addr_phase_reg <= 1'b1;
			bit_cnt_reg <= 6'h00;
			shift_reg <= 28'h0000000;
			word_valid <= 1'b0;
			word_addr <= 12'h000;
			word_data <= 28'h0000000;
		end else if (ce) begin
			sck_q_reg <= serial_clk;
			word_valid <= 1'b0;
			if (word_valid) begin
				word_addr <= word_addr + 12'h001;
			end
			if (serial_load_n) begin
				// Partial word is dropped, register untouched
				addr_phase_reg <= 1'b1;
				bit_cnt_reg <= 6'h00;
			end else if (sck_rise) begin
				// LSB first: shift in from the top
				shift_reg <= {serial_data, shift_reg[`ICR_DATA_BITS-1:1]};
				if (addr_phase_reg && bit_cnt_reg == `ICR_ADDR_BITS - 1) begin
					word_addr <= {serial_data,
						shift_reg[`ICR_DATA_BITS-1:`ICR_DATA_BITS-`ICR_ADDR_BITS+1]};
					addr_phase_reg <= 1'b0;
					bit_cnt_reg <= 6'h00;
				end else if (!addr_phase_reg && bit_cnt_reg == `ICR_DATA_BITS - 1) begin
					word_data <= {serial_data, shift_reg[`ICR_DATA_BITS-1:1]};
					word_valid <= 1'b1;
					bit_cnt_reg <= 6'h00;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 6'h01;
				end
			end
		end
	end
endmodule

// *** core/icr_regbank.v ***
// Imager control register bank: serial writes, update scheduling, control outputs
//
// Overview of operation
// - Fixed area 0x00 to 0x91 is decoded and stored, except 0x10 which triggers a soft reset.
// - Configurable area begins at 0x400: patterns, then sequences, then fields.
// - Registers 0x90 and 0x91 hold pattern group and sequence counts.
// - Pattern groups take forty words; sequences start after count times forty.
// - Sequences take twenty, fields twelve; field base follows sequence block.
// - Patterns, sequences and fields form one block without gaps.
// - Immediate class registers load when the final data bit arrives.
// - Frame class registers stay pending until frame sync falls.
// - Update line register delays frame commits; field registers ignore it.
// - Gate-line class commits at line sync fall ending a sensor gate line.
// - Pattern and sequence words commit at the change point using them.
// - Several writes before a commit point: only the last applies.
// - Control bit 2 enables black clamp, bit 3 selects fast settling.
// - Bit 4 set gives very fast clamping each time the active gain value changes.
// - During blanking outputs go to zero or to the clamp level.
// - Bit 6 clear enables dc restore during blanking, set disables it.
// - Five-bit selector picks substrate count source; codes 0-3 vertical outs.
// - Write is 12 address bits then 28 data bits, LSB first.
// - Burst words go to successive higher addresses.
`timescale 1ns/1ps
`include "icr_map.vh"
module icr_regbank #(
	parameter CFG_AW = 10,
	parameter LINE_W = 12
) (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire serial_load_n,
	input wire serial_clk,
	input wire serial_data,
	input wire frame_sync,
	input wire line_sync,
	input wire sensor_gate,
	input wire scp_pulse,
	input wire [7:0] scp_seq,
	input wire [7:0] scp_pat,
	input wire [7:0] fix_rd_addr,
	input wire [CFG_AW-1:0] cfg_rd_addr,
	input wire pixel_blanking,
	input wire [11:0] adc_data,
	input wire vertical_out_six,
	input wire vertical_out_eight,
	input wire vertical_out_nine,
	input wire vertical_out_ten,
	output reg [27:0] fix_rd_data,
	output wire [27:0] cfg_rd_data,
	output reg [1:0] standby_mode,
	output reg black_clamp_on,
	output reg clamp_settle_fast,
	output reg fast_clamp_pulse,
	output reg dc_restore_en,
	output reg [11:0] data_out,
	output reg substrate_count_signal
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function [11:0] times40;
		input [7:0] n;
		times40 = {4'h0, n} * `ICR_PAT_WORDS;
	endfunction

	function [11:0] times20;
		input [7:0] n;
		times20 = {4'h0, n} * `ICR_SEQ_WORDS;
	endfunction

	function [1:0] fix_class;
		input [7:0] a;
		if (a == `ICR_A_CTRL || a == `ICR_A_OUTFMT || a == `ICR_A_SWRESET) begin
			fix_class = `ICR_UPD_SCK;
		end else if (a >= `ICR_A_SG_FIRST && a <= `ICR_A_SG_LAST) begin
			fix_class = `ICR_UPD_SG;
		end else begin
			fix_class = `ICR_UPD_VD;
		end
	endfunction

	function [27:0] fix_default;
		input [7:0] a;
		case (a)
			`ICR_A_CTRL: fix_default = `ICR_DEF_CTRL;
			`ICR_A_OUTFMT: fix_default = `ICR_DEF_OUTFMT;
			`ICR_A_CDSGAIN: fix_default = `ICR_DEF_CDSGAIN;
			`ICR_A_GAIN: fix_default = `ICR_DEF_GAIN;
			`ICR_A_CLAMPLVL: fix_default = `ICR_DEF_CLAMPLVL;
			default: fix_default = 28'h0000000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Serial receiver
	// ------------------------------------------------------------
	wire word_valid;
	wire [11:0] word_addr;
	wire [27:0] word_data;

	icr_serial u_serial (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.serial_load_n(serial_load_n),
		.serial_clk(serial_clk),
		.serial_data(serial_data),
		.word_valid(word_valid),
		.word_addr(word_addr),
		.word_data(word_data)
	);

	// ------------------------------------------------------------
	// Fixed area storage
	// ------------------------------------------------------------
	reg [27:0] fix_act [0:`ICR_FIX_LAST];
	reg [27:0] fix_shd [0:`ICR_FIX_LAST];
	reg [`ICR_FIX_LAST:0] fix_pend_reg;
	reg swreset_reg;
	reg fs_q_reg;
	reg ls_q_reg;
	reg sg_seen_reg;
	reg line_arm_reg;
	reg [LINE_W-1:0] line_cnt_reg;
	reg [27:0] gain_prev_reg;
	integer i;

	wire fs_fall = fs_q_reg & ~frame_sync;
	wire ls_fall = ls_q_reg & ~line_sync;
	wire [27:0] ctrl = fix_act[`ICR_A_CTRL];
	wire [LINE_W-1:0] upd_line = fix_act[`ICR_A_UPDLINE][LINE_W-1:0];
	wire [7:0] pat_cnt = fix_act[`ICR_A_PATCNT][7:0];
	wire [7:0] seq_cnt = fix_act[`ICR_A_SEQCNT][7:0];
	wire fix_hit = word_valid && word_addr <= {4'h0, `ICR_FIX_LAST};
	wire [7:0] fix_wa = word_addr[7:0];
	wire [LINE_W-1:0] line_cnt_inc = line_cnt_reg + 1'b1;

	// Zero update line means commit right at the frame edge
	wire vd_now = (fs_fall && upd_line == {LINE_W{1'b0}}) ||
		(line_arm_reg && ls_fall && line_cnt_inc == upd_line);
	wire sg_now = ls_fall && (sg_seen_reg || sensor_gate);

	always @(posedge mclk) begin
		if (rst || (ce && swreset_reg)) begin
			for (i = 0; i <= `ICR_FIX_LAST; i = i + 1) begin
				fix_act[i] <= fix_default(i[7:0]);
				fix_shd[i] <= fix_default(i[7:0]);
			end
			fix_pend_reg <= {(`ICR_FIX_LAST+1){1'b0}};
			swreset_reg <= 1'b0;
			line_arm_reg <= 1'b0;
			line_cnt_reg <= {LINE_W{1'b0}};
			sg_seen_reg <= 1'b0;
			fs_q_reg <= frame_sync & ~rst;
			ls_q_reg <= line_sync & ~rst;
		end else if (ce) begin
			fs_q_reg <= frame_sync;
			ls_q_reg <= line_sync;
			swreset_reg <= 1'b0;
			// Gate line seen during the current line
			if (ls_fall) begin
				sg_seen_reg <= 1'b0;
			end else if (sensor_gate) begin
				sg_seen_reg <= 1'b1;
			end
			if (fs_fall) begin
				line_arm_reg <= upd_line != {LINE_W{1'b0}};
				line_cnt_reg <= {LINE_W{1'b0}};
			end else if (line_arm_reg && ls_fall) begin
				line_cnt_reg <= line_cnt_inc;
				if (line_cnt_inc == upd_line) begin
					line_arm_reg <= 1'b0;
				end
			end
			for (i = 0; i <= `ICR_FIX_LAST; i = i + 1) begin
				if (fix_pend_reg[i] && fix_class(i[7:0]) == `ICR_UPD_VD && vd_now) begin
					fix_act[i] <= fix_shd[i];
					fix_pend_reg[i] <= 1'b0;
				end
				if (fix_pend_reg[i] && fix_class(i[7:0]) == `ICR_UPD_SG && sg_now) begin
					fix_act[i] <= fix_shd[i];
					fix_pend_reg[i] <= 1'b0;
				end
			end
			if (fix_hit) begin
				if (fix_class(fix_wa) == `ICR_UPD_SCK) begin
					if (fix_wa == `ICR_A_SWRESET) begin
						swreset_reg <= word_data[`ICR_B_SWRESET];
					end else begin
						fix_act[fix_wa] <= word_data;
					end
				end else begin
					// A write in the commit cycle waits for the next commit
					fix_shd[fix_wa] <= word_data;
					fix_pend_reg[fix_wa] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Configurable area: shadow and active memories
	// ------------------------------------------------------------
	localparam CP_IDLE = 2'h0;
	localparam CP_PAT = 2'h1;
	localparam CP_SEQ = 2'h2;
	localparam CP_FLD = 2'h3;
	localparam [11:0] CFG_DEPTH = 12'h001 << CFG_AW;

	reg [1:0] cp_state_reg;
	reg [11:0] cp_base_reg;
	reg [11:0] cp_cnt_reg;
	reg [11:0] cp_len_reg;
	reg [7:0] cp_seq_reg;
	reg pend_fld_reg;
	reg pend_scp_reg;
	reg [7:0] pend_seq_reg;
	reg [7:0] pend_pat_reg;
	reg cp_wr_en_reg;
	reg [CFG_AW-1:0] cp_wr_addr_reg;
	wire [27:0] shd_rd_data;

	wire [11:0] cfg_off = word_addr - `ICR_CFG_BASE;
	wire cfg_hit = word_valid && word_addr >= `ICR_CFG_BASE &&
		cfg_off < CFG_DEPTH;
	wire [11:0] seq_base = times40(pat_cnt);
	wire [11:0] fld_base = seq_base + times20(seq_cnt);
	wire [11:0] cp_addr = cp_base_reg + cp_cnt_reg;
	wire cp_last = cp_cnt_reg + 12'h001 >= cp_len_reg;

	icr_mem #(.AW(CFG_AW), .DW(28)) u_shadow (
		.clk(mclk),
		.ce(ce),
		.wr_en(cfg_hit),
		.wr_addr(cfg_off[CFG_AW-1:0]),
		.wr_data(word_data),
		.rd_addr(cp_addr[CFG_AW-1:0]),
		.rd_data(shd_rd_data)
	);

	icr_mem #(.AW(CFG_AW), .DW(28)) u_active (
		.clk(mclk),
		.ce(ce),
		.wr_en(cp_wr_en_reg),
		.wr_addr(cp_wr_addr_reg),
		.wr_data(shd_rd_data),
		.rd_addr(cfg_rd_addr),
		.rd_data(cfg_rd_data)
	);

	// Copy engine moves whole blocks; a change point may stall field copy
	always @(posedge mclk) begin
		if (rst) begin
			cp_state_reg <= CP_IDLE;
			cp_base_reg <= 12'h000;
			cp_cnt_reg <= 12'h000;
			cp_len_reg <= 12'h000;
			cp_seq_reg <= 8'h00;
			pend_fld_reg <= 1'b0;
			pend_scp_reg <= 1'b0;
			pend_seq_reg <= 8'h00;
			pend_pat_reg <= 8'h00;
			cp_wr_en_reg <= 1'b0;
			cp_wr_addr_reg <= {CFG_AW{1'b0}};
		end else if (ce) begin
			cp_wr_en_reg <= cp_state_reg != CP_IDLE;
			cp_wr_addr_reg <= cp_addr[CFG_AW-1:0];
			case (cp_state_reg)
				CP_IDLE: begin
					cp_cnt_reg <= 12'h000;
					if (pend_scp_reg) begin
						pend_scp_reg <= scp_pulse;
						cp_state_reg <= CP_PAT;
						cp_base_reg <= times40(pend_pat_reg);
						cp_len_reg <= `ICR_PAT_WORDS;
						cp_seq_reg <= pend_seq_reg;
					end else if (pend_fld_reg) begin
						pend_fld_reg <= fs_fall;
						cp_state_reg <= CP_FLD;
						cp_base_reg <= fld_base;
						cp_len_reg <= CFG_DEPTH - fld_base;
					end
				end
				CP_PAT: begin
					cp_cnt_reg <= cp_cnt_reg + 12'h001;
					if (cp_last) begin
						cp_state_reg <= CP_SEQ;
						cp_cnt_reg <= 12'h000;
						cp_base_reg <= seq_base + times20(cp_seq_reg);
						cp_len_reg <= `ICR_SEQ_WORDS;
					end
				end
				CP_SEQ, CP_FLD: begin
					cp_cnt_reg <= cp_cnt_reg + 12'h001;
					if (cp_last) begin
						cp_state_reg <= CP_IDLE;
					end
				end
				default: cp_state_reg <= CP_IDLE;
			endcase
			if (scp_pulse) begin
				pend_scp_reg <= 1'b1;
				pend_seq_reg <= scp_seq;
				pend_pat_reg <= scp_pat;
			end
			// Field words follow the frame edge, not the update line
			if (fs_fall) begin
				pend_fld_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			fix_rd_data <= 28'h0000000;
			standby_mode <= 2'h3;
			black_clamp_on <= 1'b1;
			clamp_settle_fast <= 1'b0;
			fast_clamp_pulse <= 1'b0;
			dc_restore_en <= 1'b0;
			data_out <= 12'h000;
			substrate_count_signal <= 1'b0;
			gain_prev_reg <= `ICR_DEF_GAIN;
		end else if (ce) begin
			if (fix_rd_addr <= `ICR_FIX_LAST) begin
				fix_rd_data <= fix_act[fix_rd_addr];
			end else begin
				fix_rd_data <= 28'h0000000;
			end
			standby_mode <= ctrl[`ICR_B_STANDBY];
			black_clamp_on <= ctrl[`ICR_B_CLAMP_ON];
			clamp_settle_fast <= ctrl[`ICR_B_SETTLE_FAST];
			gain_prev_reg <= fix_act[`ICR_A_GAIN];
			fast_clamp_pulse <= ctrl[`ICR_B_GAIN_FAST] &&
				fix_act[`ICR_A_GAIN] != gain_prev_reg;
			dc_restore_en <= pixel_blanking & ~ctrl[`ICR_B_DC_BYPASS];
			if (pixel_blanking) begin
				if (ctrl[`ICR_B_BLANK_LVL]) begin
					// Clamp code is quarter-LSB; keep its integer part
					data_out <= {4'h0, fix_act[`ICR_A_CLAMPLVL][9:2]};
				end else begin
					data_out <= 12'h000;
				end
			end else begin
				data_out <= adc_data;
			end
			case (ctrl[`ICR_B_SUBSEL])
				5'h00: substrate_count_signal <= vertical_out_six;
				5'h01: substrate_count_signal <= vertical_out_eight;
				5'h02: substrate_count_signal <= vertical_out_nine;
				5'h03: substrate_count_signal <= vertical_out_ten;
				`ICR_SUB_HIGH: substrate_count_signal <= 1'b1;
				// Other sources live outside this block
				default: substrate_count_signal <= 1'b0;
			endcase
		end
	end
endmodule

// *** sim/icr_regbank_monitor.sv ***
// Port-level checker for the imager register bank
`timescale 1ns/1ps
module icr_regbank_monitor #(
	parameter CFG_AW = 10
) (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire serial_load_n,
	input wire frame_sync,
	input wire scp_pulse,
	input wire pixel_blanking,
	input wire [11:0] adc_data,
	input wire [7:0] fix_rd_addr,
	input wire [CFG_AW-1:0] cfg_rd_addr,
	input wire [27:0] fix_rd_data,
	input wire [27:0] cfg_rd_data,
	input wire [1:0] standby_mode,
	input wire black_clamp_on,
	input wire clamp_settle_fast,
	input wire fast_clamp_pulse,
	input wire dc_restore_en,
	input wire [11:0] data_out
);
	// ----
	// Helper counters
	// ----
	// Copies may run for hundreds of cycles, so stability is only claimed long after
	reg [3:0] load_gap;
	reg [8:0] quiet;
	reg fs_d;
	always @(posedge mclk) begin
		fs_d <= frame_sync;
		if (rst || !serial_load_n)
			load_gap <= 4'h0;
		else if (load_gap != 4'hf)
			load_gap <= load_gap + 4'h1;
		if (rst || scp_pulse || (fs_d && !frame_sync))
			quiet <= 9'h0;
		else if (quiet != 9'h1ff)
			quiet <= quiet + 9'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	standby_follows_serial_a: assert property (!$stable(standby_mode) && !$past(rst) |->
		load_gap < 4'h8) else $error("standby changed without a serial write");
	clamp_follows_serial_a: assert property ((!$stable(black_clamp_on) ||
		!$stable(clamp_settle_fast)) && !$past(rst) |-> load_gap < 4'h8)
		else $error("clamp bits changed without a serial write");
	dc_restore_cause_a: assert property ($rose(dc_restore_en) |-> $past(pixel_blanking))
		else $error("dc restore rose outside blanking");
	dc_restore_drop_a: assert property ($fell(pixel_blanking) && ce |=> !dc_restore_en)
		else $error("dc restore held after blanking");
	data_pass_a: assert property (ce && !pixel_blanking |=> data_out == $past(adc_data))
		else $error("data output not following converter");
	blank_range_a: assert property (ce && pixel_blanking |=> data_out[11:8] == 4'h0)
		else $error("blank level out of range");
	pulse_single_a: assert property (fast_clamp_pulse |=> !fast_clamp_pulse)
		else $error("fast clamp pulse too long");
	fix_unmapped_a: assert property (ce && fix_rd_addr > 8'h91 |=> fix_rd_data == 28'h0)
		else $error("unmapped fixed address read nonzero");
	cfg_active_stable_a: assert property (quiet > 9'd400 && $stable(cfg_rd_addr) && ce
		|=> cfg_rd_data === $past(cfg_rd_data)) else $error("active word moved without commit");
endmodule
bind icr_regbank icr_regbank_monitor #(.CFG_AW(CFG_AW)) u_mon (.mclk(mclk), .rst(rst),
	.ce(ce), .serial_load_n(serial_load_n), .frame_sync(frame_sync), .scp_pulse(scp_pulse),
	.pixel_blanking(pixel_blanking), .adc_data(adc_data), .fix_rd_addr(fix_rd_addr),
	.cfg_rd_addr(cfg_rd_addr), .fix_rd_data(fix_rd_data), .cfg_rd_data(cfg_rd_data),
	.standby_mode(standby_mode), .black_clamp_on(black_clamp_on),
	.clamp_settle_fast(clamp_settle_fast), .fast_clamp_pulse(fast_clamp_pulse),
	.dc_restore_en(dc_restore_en), .data_out(data_out));

// *** sim/icr_host.sv ***
// Host controller model driving the three-wire serial write port
`timescale 1ns/1ps
module icr_host (
	input wire mclk,
	output reg serial_load_n,
	output reg serial_clk,
	output reg serial_data
);
	initial begin
		serial_load_n = 1'b1;
		serial_clk = 1'b0;
		serial_data = 1'b0;
	end
	// ----
	// Bit and word tasks
	// ----
	// Each half of the serial clock lasts one master clock so every rise is seen
	task send_bit(input logic b);
		@(posedge mclk);
		#2 serial_clk = 1'b0;
		serial_data = b;
		@(posedge mclk);
		#2 serial_clk = 1'b1;
	endtask
	task start(input logic [11:0] a);
		@(posedge mclk);
		#2 serial_load_n = 1'b0;
		for (int i = 0; i < 12; i++) send_bit(a[i]);
	endtask
	task word(input logic [27:0] d);
		for (int i = 0; i < 28; i++) send_bit(d[i]);
	endtask
	task stop;
		@(posedge mclk);
		#2 serial_clk = 1'b0;
		@(posedge mclk);
		#2 serial_load_n = 1'b1;
		serial_data = ~serial_data;
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the imager register bank
`timescale 1ns/1ps
module tb;
	localparam CFG_AW = 8;
	logic mclk, rst, frame_sync, line_sync, sensor_gate, scp_pulse, pixel_blanking;
	logic ce, v6, v8, v9, v10;
	logic [7:0] scp_seq, scp_pat, fix_rd_addr;
	logic [CFG_AW-1:0] cfg_rd_addr;
	logic [11:0] adc_data;
	wire load_n, sck, sdata, black_clamp_on, clamp_settle_fast, fast_clamp_pulse;
	wire dc_restore_en, sub_cnt;
	wire [27:0] fix_rd_data, cfg_rd_data;
	wire [1:0] standby_mode;
	wire [11:0] data_out;
	int err_count, num_checks, i;
	logic [7:0] def_addr [0:6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h10, 8'h92};
	logic [27:0] def_val [0:6] = '{28'h7, 28'h8, 28'h1, 28'hf, 28'h1ec, 28'h0, 28'h0};
	icr_host host (.mclk(mclk), .serial_load_n(load_n), .serial_clk(sck), .serial_data(sdata));
	icr_regbank #(.CFG_AW(CFG_AW)) dut (.mclk(mclk), .rst(rst), .ce(ce),
		.serial_load_n(load_n), .serial_clk(sck), .serial_data(sdata),
		.frame_sync(frame_sync), .line_sync(line_sync), .sensor_gate(sensor_gate),
		.scp_pulse(scp_pulse), .scp_seq(scp_seq), .scp_pat(scp_pat),
		.fix_rd_addr(fix_rd_addr), .cfg_rd_addr(cfg_rd_addr), .pixel_blanking(pixel_blanking),
		.adc_data(adc_data), .vertical_out_six(v6), .vertical_out_eight(v8),
		.vertical_out_nine(v9), .vertical_out_ten(v10), .fix_rd_data(fix_rd_data),
		.cfg_rd_data(cfg_rd_data), .standby_mode(standby_mode), .black_clamp_on(black_clamp_on),
		.clamp_settle_fast(clamp_settle_fast), .fast_clamp_pulse(fast_clamp_pulse),
		.dc_restore_en(dc_restore_en), .data_out(data_out), .substrate_count_signal(sub_cnt));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ----
	// Access tasks
	// ----
	task report_and_stop;
		$display("TB: %0d checks, %0d mismatches", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [27:0] got, input logic [27:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t ns: %s got %h expected %h", $time, what, got, exp);
			err_count++;
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task wr(input logic [11:0] a, input logic [27:0] d);
		host.start(a);
		host.word(d);
		host.stop();
		tick(4);
	endtask
	task rd_fix(input logic [7:0] a, input logic [27:0] exp, input string what);
		fix_rd_addr = a;
		tick(1);
		chk(fix_rd_data, exp, what);
	endtask
	task rd_cfg(input logic [CFG_AW-1:0] a, input logic [27:0] exp, input string what);
		cfg_rd_addr = a;
		tick(1);
		chk(cfg_rd_data, exp, what);
	endtask
	// Returns right at the falling edge so a one-cycle answer is not missed
	task frame;
		frame_sync = 1'b1;
		tick(3);
		frame_sync = 1'b0;
	endtask
	task line(input logic g);
		sensor_gate = g;
		tick(2);
		sensor_gate = 1'b0;
		line_sync = 1'b1;
		tick(2);
		line_sync = 1'b0;
		tick(4);
	endtask
	task wait_pulse;
		int k;
		for (k = 0; k < 20 && fast_clamp_pulse !== 1'b1; k++) tick(1);
		num_checks++;
		if (k == 20) begin
			$display("CHECK FAILED at %0t ns: no fast clamp pulse", $time);
			err_count++;
			report_and_stop();
		end
	endtask
	// ----
	// Test sequence
	// ----
	initial begin
		{rst, frame_sync, line_sync, sensor_gate, scp_pulse, pixel_blanking} = 6'h20;
		{ce, v6, v8, v9, v10} = 5'h10;
		{scp_seq, scp_pat, fix_rd_addr, cfg_rd_addr} = '0;
		adc_data = 12'h5a5;
		tick(2);
		rst = 1'b0;
		for (i = 0; i < 7; i++) rd_fix(def_addr[i], def_val[i], "reset default");
		chk({26'h0, standby_mode}, 28'h3, "standby at reset");
		chk({27'h0, black_clamp_on}, 28'h1, "clamp at reset");
		$display("TB: defaults done");
		wr(12'h000, 28'h38);
		chk({26'h0, standby_mode}, 28'h0, "standby");
		chk({26'h0, clamp_settle_fast, black_clamp_on}, 28'h2, "clamp bits");
		pixel_blanking = 1'b1;
		tick(2);
		chk({16'h0, data_out}, 28'h7b, "blank level");
		chk({27'h0, dc_restore_en}, 28'h1, "dc restore on");
		wr(12'h000, 28'h58);
		chk({16'h0, data_out}, 28'h0, "blank zero");
		chk({27'h0, dc_restore_en}, 28'h0, "dc restore off");
		pixel_blanking = 1'b0;
		tick(2);
		chk({16'h0, data_out}, {16'h0, adc_data}, "pass through");
		ce = 1'b0;
		adc_data = 12'h3c3;
		tick(3);
		chk({16'h0, data_out}, 28'h5a5, "frozen output");
		ce = 1'b1;
		tick(2);
		chk({16'h0, data_out}, 28'h3c3, "pass through after freeze");
		for (i = 0; i < 6; i++) begin
			{v10, v9, v8, v6} = (i < 4) ? (4'h1 << i) : {4{i == 5}};
			wr(12'h000, {12'h0, 5'(i < 4 ? i : i + 26), 11'h38});
			chk({27'h0, sub_cnt}, {27'h0, i != 5}, "substrate select");
		end
		$display("TB: control done");
		host.start(12'h004);
		host.word(28'h2);
		host.word(28'h10);
		host.word(28'h1ff);
		host.stop();
		wr(12'h005, 28'h20);
		rd_fix(8'h05, 28'hf, "gain held");
		frame();
		wait_pulse();
		tick(4);
		rd_fix(8'h04, 28'h2, "burst word 0");
		rd_fix(8'h05, 28'h20, "last gain write");
		rd_fix(8'h06, 28'h1ff, "burst word 2");
		pixel_blanking = 1'b1;
		tick(2);
		chk({16'h0, data_out}, 28'h7f, "new clamp level");
		pixel_blanking = 1'b0;
		wr(12'h070, 28'h5);
		line(1'b0);
		rd_fix(8'h70, 28'h0, "gate class held");
		line(1'b1);
		rd_fix(8'h70, 28'h5, "gate class commit");
		$display("TB: update classes done");
		host.start(12'h090);
		host.word(28'h2);
		host.word(28'h2);
		host.stop();
		frame();
		tick(300);
		host.start(12'h44f);
		host.word(28'habcdef);
		host.word(28'h1111111);
		host.stop();
		wr(12'h464, 28'h1111111);
		wr(12'h464, 28'h2222222);
		{scp_seq, scp_pat, scp_pulse} = 17'h00203;
		tick(1);
		scp_pulse = 1'b0;
		tick(80);
		rd_cfg(79, 28'habcdef, "pattern tail");
		rd_cfg(100, 28'h2222222, "sequence head");
		wr(12'h018, 28'h2);
		frame();
		tick(300);
		wr(12'h478, 28'h3333333);
		wr(12'h005, 28'h30);
		frame();
		tick(450);
		rd_cfg(120, 28'h3333333, "field commit");
		rd_fix(8'h05, 28'h20, "update line hold");
		line(1'b0);
		line(1'b0);
		rd_fix(8'h05, 28'h30, "update line commit");
		$display("TB: configurable area done");
		wr(12'h010, 28'h1);
		rd_fix(8'h05, 28'hf, "soft reset gain");
		rd_fix(8'h00, 28'h7, "soft reset control");
		$display("TB: soft reset done");
		report_and_stop();
	end
endmodule
